// *** logic/mtt_ms_tick.sv ***
`timescale 1ns/100ps
module mtt_ms_tick
  import mtt_pkg::*;
#(
  parameter int unsigned CYCLES = TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // One pulse per millisecond.
  output logic tick
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_r;
  logic tick_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (cnt_r == CW'(CYCLES - 1)) begin
      cnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  assign tick = tick_r;

endmodule

// *** logic/mtt_pkg.sv ***
package mtt_pkg;

  // ----------------------------------------
  // Sizes and timing
  // ----------------------------------------
  localparam int TMR_NUM = 8;
  localparam int TMR_IDX_W = 3;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [30:0] TICK_MAX = 31'h7fffffff;
  localparam logic [31:0] INTERVAL_MIN = 32'h00000001;
  localparam logic [31:0] INTERVAL_MAX = 32'h8000270f;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_INTERVAL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_ARM = 8'h08;
  localparam logic [7:0] OFS_DISARM = 8'h0c;
  localparam logic [7:0] OFS_QUERY_SEL = 8'h10;
  localparam logic [7:0] OFS_REMAIN = 8'h14;
  localparam logic [7:0] OFS_EVENT = 8'h18;
  localparam logic [7:0] OFS_ERR = 8'h1c;
  localparam logic [7:0] OFS_TICK = 8'h20;
  localparam logic [7:0] OFS_START = 8'h24;
  localparam logic [7:0] OFS_ELAPSED = 8'h28;
  localparam logic [7:0] OFS_INFO_SEL = 8'h2c;
  localparam logic [7:0] OFS_INFO = 8'h30;

  // ----------------------------------------
  // Error codes, information items, reset values
  // ----------------------------------------
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_INVALID_TIMER = 2'h1;
  localparam logic [1:0] ERR_INVALID_INTERVAL = 2'h2;
  localparam logic [31:0] INFO_TMR_GRAN = 32'h000007d2;
  localparam logic [31:0] INFO_TMR_COUNT = 32'h000007d3;
  localparam logic [31:0] INFO_TICK_RES = 32'h000007d4;
  localparam logic [31:0] TMR_GRAN_US = 32'h000003e8;
  localparam logic [31:0] TICK_RES_US = 32'h000003e8;
  localparam logic [31:0] REG_RESET = 32'h00000000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } mtt_bus_t;

  typedef struct packed {
    logic [30:0] reload;
    logic [30:0] remain;
    logic active;
    logic recur;
  } mtt_entry_t;

  typedef enum logic [1:0] {SC_IDLE, SC_RD, SC_WB} mtt_scan_t;

endpackage

// *** logic/mtt_tmr_mem.sv ***
`timescale 1ns/100ps
module mtt_tmr_mem
  import mtt_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Write port.
  input wire logic we,
  input wire logic [TMR_IDX_W-1:0] waddr,
  input wire mtt_entry_t wdata,
  // Registered read ports.
  input wire logic [TMR_IDX_W-1:0] raddr_a,
  output mtt_entry_t rdata_a,
  input wire logic [TMR_IDX_W-1:0] raddr_b,
  output mtt_entry_t rdata_b
);

  // Read-before-write: a read of the word being written returns the old value.
  mtt_entry_t mem [TMR_NUM];
  mtt_entry_t rd_a_r;
  mtt_entry_t rd_b_r;

  initial begin
    for (int i = 0; i < TMR_NUM; i++) begin
      mem[i] = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rd_a_r <= mem[raddr_a];
    rd_b_r <= mem[raddr_b];
  end

  assign rdata_a = rd_a_r;
  assign rdata_b = rd_b_r;

endmodule

// *** logic/mtt_top.sv ***
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module mtt_top
  import mtt_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Register port.
  input wire mtt_bus_t bus,
  output logic [31:0] rdata,
  // Expiry flags.
  output logic [TMR_NUM-1:0] timer_expiry_event
);

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  function automatic logic idx_ok(input logic [31:0] v);
    return v < 32'(TMR_NUM);
  endfunction

  logic ms_tick;
  logic [31:0] interval_r;
  logic [31:0] mode_r;
  logic [TMR_IDX_W-1:0] sel_r;
  logic [TMR_NUM-1:0] evt_r;
  logic [TMR_NUM-1:0] evt_nxt;
  logic [1:0] err_r;
  logic [30:0] tick_r;
  logic [31:0] start_r;
  logic [30:0] elapsed_r;
  logic [31:0] info_sel_r;
  logic [31:0] rdata_r;
  logic tick_pend_r;
  logic hit_r;
  mtt_scan_t state_r;
  mtt_scan_t state_nxt;
  logic [TMR_IDX_W-1:0] scan_idx_r;
  mtt_entry_t rd_a;
  mtt_entry_t rd_b;

  wire wr_interval = bus.wr && bus.addr == OFS_INTERVAL;
  wire wr_mode = bus.wr && bus.addr == OFS_MODE;
  wire wr_arm = bus.wr && bus.addr == OFS_ARM;
  wire wr_disarm = bus.wr && bus.addr == OFS_DISARM;
  wire wr_query = bus.wr && bus.addr == OFS_QUERY_SEL;
  wire wr_event = bus.wr && bus.addr == OFS_EVENT;
  wire wr_start = bus.wr && bus.addr == OFS_START;
  wire wr_info = bus.wr && bus.addr == OFS_INFO_SEL;
  wire wdata_idx_ok = idx_ok(bus.wdata);
  wire [TMR_IDX_W-1:0] cmd_idx = bus.wdata[TMR_IDX_W-1:0];

  // Negative and oversized intervals are both caught; the sign test alone covers both.
  wire interval_ok = interval_r >= INTERVAL_MIN && !interval_r[31] && interval_r <= INTERVAL_MAX;
  wire arm_go = wr_arm && wdata_idx_ok && interval_ok;
  wire disarm_go = wr_disarm && wdata_idx_ok;
  wire cmd_we = arm_go || disarm_go;

  // ----------------------------------------
  // Timer table
  // ----------------------------------------
  mtt_entry_t arm_ent;
  assign arm_ent.reload = interval_r[30:0];
  assign arm_ent.remain = interval_r[30:0];
  assign arm_ent.active = 1'b1;
  assign arm_ent.recur = |mode_r;

  wire at_end = rd_a.active && rd_a.remain == 31'h00000001;
  wire retry = cmd_we || hit_r;
  wire scan_we = state_r == SC_WB && !retry;
  wire expire_now = scan_we && at_end;

  mtt_entry_t scan_ent;
  assign scan_ent.reload = rd_a.reload;
  assign scan_ent.recur = rd_a.recur;
  assign scan_ent.active = rd_a.active && !(at_end && !rd_a.recur);
  assign scan_ent.remain = !rd_a.active ? rd_a.remain :
                           at_end ? (rd_a.recur ? rd_a.reload : 31'h00000000) :
                           rd_a.remain - 31'h00000001;

  wire mem_we = cmd_we || scan_we;
  wire [TMR_IDX_W-1:0] mem_waddr = cmd_we ? cmd_idx : scan_idx_r;
  mtt_entry_t mem_wdata;
  assign mem_wdata = arm_go ? arm_ent : disarm_go ? mtt_entry_t'('0) : scan_ent;

  mtt_tmr_mem u_mem (
    .clk(clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr_a(scan_idx_r),
    .rdata_a(rd_a),
    .raddr_b(sel_r),
    .rdata_b(rd_b)
  );

  mtt_ms_tick #(.CYCLES(TICK_CYCLES_P)) u_tick (
    .clk(clk),
    .srst(srst),
    .tick(ms_tick)
  );

  // ----------------------------------------
  // Millisecond sweep
  // ----------------------------------------
  // A command write owns the table port, so the sweep retries that word; a host
  // writing commands on every cycle would hold the sweep off.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SC_IDLE: if (tick_pend_r) state_nxt = SC_RD;
      SC_RD: state_nxt = SC_WB;
      SC_WB: begin
        if (!retry && scan_idx_r == TMR_IDX_W'(TMR_NUM - 1)) begin
          state_nxt = SC_IDLE;
        end else begin
          state_nxt = SC_RD;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= SC_IDLE;
      scan_idx_r <= '0;
      tick_pend_r <= 1'b0;
      hit_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hit_r <= cmd_we && cmd_idx == scan_idx_r;
      tick_pend_r <= ms_tick || (tick_pend_r && state_r != SC_IDLE);
      if (state_r == SC_IDLE) begin
        scan_idx_r <= '0;
      end else if (scan_we) begin
        scan_idx_r <= scan_idx_r + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Event flags
  // ----------------------------------------
  // A new expiry wins over a clear that lands in the same cycle.
  for (genvar i = 0; i < TMR_NUM; i++) begin : g_evt
    assign evt_nxt[i] = (expire_now && scan_idx_r == TMR_IDX_W'(i)) ||
                        (evt_r[i] && !(wr_event && bus.wdata[i]));
  end

  // ----------------------------------------
  // Tick counter and elapsed time
  // ----------------------------------------
  wire [30:0] tick_inc = (tick_r == TICK_MAX) ? 31'h00000000 : tick_r + 31'h00000001;
  wire [30:0] since_fwd = 31'(tick_r - start_r[30:0]);
  wire [30:0] since_wrap = 31'((TICK_MAX - start_r[30:0]) + tick_r);
  wire [30:0] elapsed_nxt = start_r[31] ? 31'h00000000 :
                            (tick_r >= start_r[30:0]) ? since_fwd : since_wrap;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  wire [31:0] info_val = (info_sel_r == INFO_TICK_RES) ? TICK_RES_US :
                         (info_sel_r == INFO_TMR_COUNT) ? 32'(TMR_NUM) :
                         (info_sel_r == INFO_TMR_GRAN) ? TMR_GRAN_US : 32'h00000000;
  wire [31:0] remain_val = rd_b.active ? {1'b0, rd_b.remain} : 32'h00000000;
  wire [31:0] rd_val = (bus.addr == OFS_INTERVAL) ? interval_r :
                       (bus.addr == OFS_MODE) ? mode_r :
                       (bus.addr == OFS_QUERY_SEL) ? {{(32 - TMR_IDX_W){1'b0}}, sel_r} :
                       (bus.addr == OFS_REMAIN) ? remain_val :
                       (bus.addr == OFS_EVENT) ? {{(32 - TMR_NUM){1'b0}}, evt_r} :
                       (bus.addr == OFS_ERR) ? {30'h00000000, err_r} :
                       (bus.addr == OFS_TICK) ? {1'b0, tick_r} :
                       (bus.addr == OFS_START) ? start_r :
                       (bus.addr == OFS_ELAPSED) ? {1'b0, elapsed_r} :
                       (bus.addr == OFS_INFO_SEL) ? info_sel_r :
                       (bus.addr == OFS_INFO) ? info_val : 32'h00000000;

  wire cmd_seen = wr_arm || wr_disarm || wr_query;
  wire [1:0] err_nxt = !wdata_idx_ok ? ERR_INVALID_TIMER :
                       (wr_arm && !interval_ok) ? ERR_INVALID_INTERVAL : ERR_NONE;

  always_ff @(posedge clk) begin
    if (srst) begin
      interval_r <= REG_RESET;
      mode_r <= REG_RESET;
      sel_r <= '0;
      evt_r <= '0;
      err_r <= ERR_NONE;
      tick_r <= '0;
      start_r <= REG_RESET;
      elapsed_r <= '0;
      info_sel_r <= REG_RESET;
      rdata_r <= REG_RESET;
    end else begin
      if (wr_interval) interval_r <= bus.wdata;
      if (wr_mode) mode_r <= bus.wdata;
      if (wr_query && wdata_idx_ok) sel_r <= cmd_idx;
      if (cmd_seen) err_r <= err_nxt;
      if (wr_start) start_r <= bus.wdata;
      if (wr_info) info_sel_r <= bus.wdata;
      if (ms_tick) tick_r <= tick_inc;
      evt_r <= evt_nxt;
      elapsed_r <= elapsed_nxt;
      rdata_r <= bus.rd ? rd_val : 32'h00000000;
    end
  end

  assign rdata = rdata_r;
  assign timer_expiry_event = evt_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  property p_tick_wrap;
    ms_tick && tick_r == TICK_MAX |=> tick_r == 31'h00000000;
  endproperty
  a_tick_wrap: assert property (p_tick_wrap) else $error("tick counter did not wrap");

  property p_tick_step;
    ms_tick && tick_r != TICK_MAX |=> tick_r == $past(tick_r) + 31'h00000001;
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("tick counter did not advance");

  property p_tick_hold;
    !ms_tick |=> $stable(tick_r);
  endproperty
  a_tick_hold: assert property (p_tick_hold) else $error("tick counter moved off tick");

  property p_arm_bad_idx;
    wr_arm && !wdata_idx_ok |=> err_r == ERR_INVALID_TIMER && !$past(mem_we && !scan_we);
  endproperty
  a_arm_bad_idx: assert property (p_arm_bad_idx) else $error("bad arm index not refused");

  property p_arm_bad_int;
    wr_arm && wdata_idx_ok && (interval_r == 32'h00000000 || interval_r[31]) |=> err_r == ERR_INVALID_INTERVAL;
  endproperty
  a_arm_bad_int: assert property (p_arm_bad_int) else $error("bad interval not refused");

  property p_disarm_bad;
    (wr_disarm || wr_query) && !wdata_idx_ok |=> err_r == ERR_INVALID_TIMER;
  endproperty
  a_disarm_bad: assert property (p_disarm_bad) else $error("bad index gave wrong error");

  property p_since_neg;
    start_r[31] ##1 start_r[31] |-> elapsed_r == 31'h00000000;
  endproperty
  a_since_neg: assert property (p_since_neg) else $error("negative start gave nonzero");

  property p_expiry_flag;
    expire_now |=> evt_r[$past(scan_idx_r)];
  endproperty
  a_expiry_flag: assert property (p_expiry_flag) else $error("expiry flag not set");

  // Every flag that is set and not being cleared must still be set a cycle later.
  wire [TMR_NUM-1:0] evt_keep = evt_r & ~(wr_event ? bus.wdata[TMR_NUM-1:0] : {TMR_NUM{1'b0}});

  property p_flag_sticky;
    (|evt_keep) |=> (evt_r & $past(evt_keep)) == $past(evt_keep);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("event flag dropped");

  property p_info_count;
    bus.rd && bus.addr == OFS_INFO && info_sel_r == INFO_TMR_COUNT |=> rdata == 32'(TMR_NUM);
  endproperty
  a_info_count: assert property (p_info_count) else $error("timer count item wrong");

  property p_cov_arm;
    arm_go ##[1:3] scan_we;
  endproperty
  c_arm: cover property (p_cov_arm);

  property p_cov_expire;
    expire_now && rd_a.recur;
  endproperty
  c_expire: cover property (p_cov_expire);

  property p_cov_wrap;
    ms_tick && tick_r == TICK_MAX;
  endproperty
  c_wrap: cover property (p_cov_wrap);

endmodule

// *** testbench/multi_timer_and_tick_counter_test.sv ***
`timescale 1ns/100ps
module multi_timer_and_tick_counter_test;
  import mtt_pkg::*;

  // ----------------------------------------
  // Clock, reset and device
  // ----------------------------------------
  // A short millisecond keeps the run small; wait_ms and wait_flag below count in these units.
  localparam int unsigned TC = 40;
  logic clk = 1'b0;
  logic srst = 1'b1;
  mtt_bus_t bus = '0;
  logic [31:0] rdata;
  logic [TMR_NUM-1:0] timer_expiry_event;
  int fails = 0;
  int tests_run = 0;

  mtt_top #(.TICK_CYCLES_P(TC)) i_dut (
    .clk(clk),
    .srst(srst),
    .bus(bus),
    .rdata(rdata),
    .timer_expiry_event(timer_expiry_event)
  );

  always #12.5 clk = ~clk;

  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    tests_run++;
    if ((got >= lo) !== 1'b1 || (got <= hi) !== 1'b1) begin
      $display("ERROR %0t: got %h, expected %h..%h", $time, got, lo, hi);
      fails++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= {1'b1, 1'b0, a, d};
    @(posedge clk);
    bus <= '0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= {1'b0, 1'b1, a, 32'h0};
    @(posedge clk);
    bus <= '0;
    #1;
    d = rdata;
  endtask

  task automatic rq(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    logic [31:0] d;
    rd(a, d);
    chk(d, lo, hi);
  endtask

  task automatic err_is(input logic [1:0] e);
    rq(OFS_ERR, 32'(e), 32'(e));
  endtask

  task automatic ev_is(input logic [31:0] e);
    #1;
    chk(32'(timer_expiry_event), e, e);
  endtask

  task automatic arm(input logic [31:0] i, input logic [31:0] ms, input logic [31:0] mode);
    wr(OFS_INTERVAL, ms);
    wr(OFS_MODE, mode);
    wr(OFS_ARM, i);
  endtask

  task automatic wait_ms(input int n);
    repeat (n * TC) @(posedge clk);
  endtask

  // Bounded wait; the caller judges the flags afterwards, so a hang shows as a mismatch.
  task automatic wait_flag(input int i, input int ms);
    int k;
    for (k = 0; k < ms * TC && timer_expiry_event[i] !== 1'b1; k++) begin
      @(posedge clk);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_info;
    wr(OFS_INFO_SEL, INFO_TMR_GRAN);
    rq(OFS_INFO, TMR_GRAN_US, TMR_GRAN_US);
    wr(OFS_INFO_SEL, INFO_TMR_COUNT);
    rq(OFS_INFO, 32'(TMR_NUM), 32'(TMR_NUM));
    wr(OFS_INFO_SEL, INFO_TICK_RES);
    rq(OFS_INFO, TICK_RES_US, TICK_RES_US);
  endtask

  task automatic t_tick;
    logic [31:0] a;
    logic [31:0] b;
    rd(OFS_TICK, a);
    wait_ms(10);
    rd(OFS_TICK, b);
    chk(b - a, 32'h0000000a, 32'h0000000b);
    chk(b, 32'h0, {1'b0, TICK_MAX});
    wr(OFS_START, b);
    rq(OFS_ELAPSED, 32'h0, 32'h1);
    wr(OFS_START, 32'h7ffffff0);
    rq(OFS_ELAPSED, b + 32'hf, b + 32'h11);
    wr(OFS_START, 32'h80000005);
    rq(OFS_ELAPSED, 32'h0, 32'h0);
  endtask

  task automatic t_err;
    arm(8, 100, 0);
    err_is(ERR_INVALID_TIMER);
    arm(0, 0, 0);
    err_is(ERR_INVALID_INTERVAL);
    arm(0, 32'h80000000, 0);
    err_is(ERR_INVALID_INTERVAL);
    wr(OFS_QUERY_SEL, 0);
    rq(OFS_REMAIN, 32'h0, 32'h0);
    wr(OFS_DISARM, 9);
    err_is(ERR_INVALID_TIMER);
    arm(0, 32'h7fffffff, 0);
    err_is(ERR_NONE);
    wr(OFS_QUERY_SEL, 8);
    err_is(ERR_INVALID_TIMER);
    rq(OFS_QUERY_SEL, 32'h0, 32'h0);
    rq(OFS_REMAIN, 32'h7ffffffe, 32'h7fffffff);
    wr(OFS_DISARM, 0);
    rq(OFS_REMAIN, 32'h0, 32'h0);
  endtask

  task automatic t_oneshot;
    arm(2, 3, 0);
    wr(OFS_QUERY_SEL, 2);
    rq(OFS_REMAIN, 32'h2, 32'h3);
    wait_flag(2, 5);
    ev_is(32'h4);
    rq(OFS_REMAIN, 32'h0, 32'h0);
    wait_ms(5);
    ev_is(32'h4);
    wr(OFS_EVENT, 32'h4);
    ev_is(32'h0);
    wait_ms(5);
    ev_is(32'h0);
  endtask

  task automatic t_recur;
    arm(1, 12, 7);
    wait_flag(1, 13);
    ev_is(32'h2);
    wr(OFS_EVENT, 32'h2);
    wait_ms(10);
    ev_is(32'h0);
    wait_flag(1, 4);
    ev_is(32'h2);
    // Stop first, then clear, so a late expiry cannot slip in between.
    wr(OFS_DISARM, 1);
    wr(OFS_EVENT, 32'h2);
    wait_ms(14);
    ev_is(32'h0);
  endtask

  task automatic t_rearm;
    arm(3, 50, 0);
    wait_ms(3);
    arm(3, 20, 0);
    wr(OFS_QUERY_SEL, 3);
    rq(OFS_REMAIN, 32'h13, 32'h14);
    arm(3, 40, 0);
    rq(OFS_REMAIN, 32'h27, 32'h28);
    wait_ms(37);
    ev_is(32'h0);
    wait_flag(3, 5);
    ev_is(32'h8);
    wr(OFS_EVENT, 32'h8);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_info;
    t_tick;
    t_err;
    t_oneshot;
    t_recur;
    t_rearm;
    print_verdict;
  end

  // The scenarios need about 4300 cycles; this leaves ample margin.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict;
  end
endmodule
